// ===== verilog/spm_regbank.sv
// Purpose: software-visible register bank of the serial peripheral unit
// Assumes: peripheral bus with setup and access phases and byte strobes
// Notes:   read data is captured in the setup phase, so pready stays high
module spm_regbank #(
  parameter int SYNC_CYCLES = spm_pkg::SYNC_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic access_protection_lock,
  input wire logic [7:0] event_set,
  input wire logic [15:0] status_set,
  input wire logic [8:0] rx_data,
  output logic [31:0] primary_control,
  output logic [31:0] secondary_control,
  output logic [7:0] bit_rate_divisor,
  output logic [31:0] slave_match_compare,
  output logic [7:0] halt_behaviour_ctl,
  output logic [7:0] irq_enable,
  output logic [7:0] irq_flags,
  output logic shift_order_select,
  output logic core_enable,
  output logic rx_enable,
  output logic [8:0] tx_data,
  output logic tx_data_write,
  output logic rx_data_read
);

  logic access;
  logic wr;
  logic rd;
  logic setup;
  logic sw_busy;
  logic sw_done;
  logic en_busy;
  logic en_done;
  logic cb_busy;
  logic cb_done;
  logic err_sw;
  logic err_en;
  logic err_cb;
  logic wr_ok;
  logic wp_ok;
  logic soft_start;
  logic soft_clr;
  logic gen_wr;
  logic pri_we;
  logic sec_we;
  logic baud_we;
  logic addr_we;
  logic dbg_we;
  logic data_we;
  logic en_start;
  logic cb_start;
  logic enabled;
  logic [31:0] pri_q;
  logic [31:0] sec_q;
  logic [31:0] addr_q;
  logic [15:0] data_q;
  logic [7:0] baud_q;
  logic [7:0] dbg_q;
  logic [7:0] inten_q;
  logic [7:0] flags_q;
  logic [15:0] status_q;
  logic [31:0] pri_wm;
  logic [31:0] sec_wm;
  logic [7:0] baud_wm;
  logic [31:0] addr_wm;
  logic [31:0] pri_view;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  logic core_enable_q;
  logic rx_enable_q;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a[5:2] == ofs[5:2]);
  endfunction

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign setup = psel & ~penable;
  assign enabled = pri_q[spm_pkg::PRI_ENABLE];

  // bus errors: any write during soft reset, or a write to the lane of a sync op still in flight
  assign err_sw = wr & sw_busy;
  assign err_en = wr & hit(paddr, spm_pkg::OFS_PRI_CTL) &
                  pstrb[spm_pkg::LANE_PRI_LOW] & en_busy;
  assign err_cb = wr & hit(paddr, spm_pkg::OFS_SEC_CTL) &
                  pstrb[spm_pkg::LANE_SEC_RX] & cb_busy;
  assign pslverr = err_sw | err_en | err_cb;
  assign pready = 1'b1;

  assign wr_ok = wr & ~pslverr;
  assign wp_ok = wr_ok & ~access_protection_lock;

  // soft reset wins over every other field of the same write
  assign soft_start = wp_ok & hit(paddr, spm_pkg::OFS_PRI_CTL) &
                      pstrb[spm_pkg::LANE_PRI_LOW] &
                      pwdata[spm_pkg::PRI_SOFT_RST];
  assign soft_clr = soft_start;
  assign gen_wr = wp_ok & ~soft_start;

  assign pri_we = gen_wr & hit(paddr, spm_pkg::OFS_PRI_CTL);
  assign sec_we = gen_wr & hit(paddr, spm_pkg::OFS_SEC_CTL);
  assign baud_we = gen_wr & hit(paddr, spm_pkg::OFS_BAUD);
  assign addr_we = gen_wr & hit(paddr, spm_pkg::OFS_ADDR);
  assign dbg_we = gen_wr & hit(paddr, spm_pkg::OFS_HALT_CTL);
  assign data_we = wr_ok & ~soft_start & hit(paddr, spm_pkg::OFS_DATA);

  // only the enable lane and the receive enable lane start a sync; the shift order lane never does
  assign en_start = pri_we & pstrb[spm_pkg::LANE_PRI_LOW];
  assign cb_start = sec_we & pstrb[spm_pkg::LANE_SEC_RX];

  // enable-protected bits drop out of the mask while enabled
  assign pri_wm = enabled ?
    (spm_pkg::PRI_WMASK & spm_pkg::PRI_EP_FREE) :
    spm_pkg::PRI_WMASK;
  assign sec_wm = enabled ?
    (spm_pkg::SEC_WMASK & spm_pkg::SEC_EP_FREE) :
    spm_pkg::SEC_WMASK;
  assign baud_wm = enabled ? 8'h00 : spm_pkg::BAUD_WMASK;
  assign addr_wm = enabled ? 32'h0000_0000 : spm_pkg::ADDR_WMASK;

  spm_sync_busy #(
    .CYCLES(SYNC_CYCLES)
  ) u_sync_soft (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(soft_start),
    .busy(sw_busy),
    .done(sw_done)
  );

  spm_sync_busy #(
    .CYCLES(SYNC_CYCLES)
  ) u_sync_enable (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(en_start),
    .busy(en_busy),
    .done(en_done)
  );

  spm_sync_busy #(
    .CYCLES(SYNC_CYCLES)
  ) u_sync_secondary_control (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(cb_start),
    .busy(cb_busy),
    .done(cb_done)
  );

  spm_lane_reg #(
    .W(32),
    .RST(spm_pkg::PRI_RST)
  ) u_pri (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(soft_clr),
    .we(pri_we),
    .be(pstrb),
    .wd(pwdata),
    .wm(pri_wm),
    .value_q(pri_q)
  );

  spm_lane_reg #(
    .W(32),
    .RST(spm_pkg::SEC_RST)
  ) u_sec (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(soft_clr),
    .we(sec_we),
    .be(pstrb),
    .wd(pwdata),
    .wm(sec_wm),
    .value_q(sec_q)
  );

  spm_lane_reg #(
    .W(8),
    .RST(spm_pkg::BAUD_RST)
  ) u_baud (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(soft_clr),
    .we(baud_we),
    .be(pstrb[0]),
    .wd(pwdata[7:0]),
    .wm(baud_wm),
    .value_q(baud_q)
  );

  spm_lane_reg #(
    .W(32),
    .RST(spm_pkg::ADDR_RST)
  ) u_addr (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(soft_clr),
    .we(addr_we),
    .be(pstrb),
    .wd(pwdata),
    .wm(addr_wm),
    .value_q(addr_q)
  );

  spm_lane_reg #(
    .W(16),
    .RST(spm_pkg::DATA_RST)
  ) u_data (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(soft_clr),
    .we(data_we),
    .be(pstrb[1:0]),
    .wd(pwdata[15:0]),
    .wm(spm_pkg::DATA_WMASK),
    .value_q(data_q)
  );

  // debug control survives the soft reset
  spm_lane_reg #(
    .W(8),
    .RST(spm_pkg::DBG_RST)
  ) u_dbg (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(1'b0),
    .we(dbg_we),
    .be(pstrb[0]),
    .wd(pwdata[7:0]),
    .wm(spm_pkg::DBG_WMASK),
    .value_q(dbg_q)
  );

  // enable mask: set lane and clear lane share one word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      inten_q <= spm_pkg::INTEN_RST;
    end else if (soft_clr) begin
      inten_q <= spm_pkg::INTEN_RST;
    end else if (gen_wr && hit(paddr, spm_pkg::OFS_IRQ_EN_CLR)) begin
      inten_q <= (inten_q &
        ~(pstrb[spm_pkg::LANE_EN_CLR] ?
          pwdata[7:0] & spm_pkg::IRQ_MASK : 8'h00)) |
        (pstrb[spm_pkg::LANE_EN_SET] ?
          pwdata[23:16] & spm_pkg::IRQ_MASK : 8'h00);
    end
  end

  // event flags: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= spm_pkg::FLAGS_RST;
    end else if (soft_clr) begin
      flags_q <= spm_pkg::FLAGS_RST;
    end else if (wr_ok && hit(paddr, spm_pkg::OFS_IRQ_FLAGS) &&
                 pstrb[spm_pkg::LANE_FLAGS]) begin
      flags_q <= (flags_q & ~pwdata[7:0]) |
                 (event_set & spm_pkg::IRQ_MASK);
    end else begin
      flags_q <= flags_q | (event_set & spm_pkg::IRQ_MASK);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= spm_pkg::STATUS_RST;
    end else if (soft_clr) begin
      status_q <= spm_pkg::STATUS_RST;
    end else if (wr_ok && hit(paddr, spm_pkg::OFS_STATUS)) begin
      status_q <= (status_q &
        ~({pstrb[3] ? pwdata[31:24] : 8'h00,
           pstrb[2] ? pwdata[23:16] : 8'h00} & spm_pkg::STATUS_W1C)) |
        (status_set & spm_pkg::STATUS_W1C);
    end else begin
      status_q <= status_q | (status_set & spm_pkg::STATUS_W1C);
    end
  end

  // core-side enables change only when their sync or the soft reset sync completes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_enable_q <= 1'b0;
    end else if (sw_done) begin
      core_enable_q <= 1'b0;
    end else if (en_done) begin
      core_enable_q <= enabled;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_enable_q <= 1'b0;
    end else if (sw_done) begin
      rx_enable_q <= 1'b0;
    end else if (cb_done) begin
      rx_enable_q <= sec_q[spm_pkg::SEC_RX_EN];
    end
  end

  // soft reset bit reads one while the reset is in progress
  assign pri_view = {1'b0, pri_q[30:1], sw_busy};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr[5:2])
      spm_pkg::OFS_PRI_CTL[5:2]: rd_mux = pri_view;
      spm_pkg::OFS_SEC_CTL[5:2]: rd_mux = sec_q;
      spm_pkg::OFS_BAUD[5:2]: rd_mux = {24'h00_0000, baud_q};
      spm_pkg::OFS_IRQ_EN_CLR[5:2]: rd_mux = {8'h00, inten_q, 8'h00, inten_q};
      spm_pkg::OFS_IRQ_FLAGS[5:2]: rd_mux = {status_q, 8'h00, flags_q};
      spm_pkg::OFS_SYNC_PEND[5:2]:
        rd_mux = {29'h0000_0000, cb_busy, en_busy, sw_busy};
      spm_pkg::OFS_ADDR[5:2]: rd_mux = addr_q;
      spm_pkg::OFS_DATA[5:2]: rd_mux = {23'h00_0000, rx_data};
      spm_pkg::OFS_HALT_CTL[5:2]: rd_mux = {24'h00_0000, dbg_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      rdata_q <= rd_mux;
    end
  end

  assign prdata = rdata_q;
  assign primary_control = pri_view;
  assign secondary_control = sec_q;
  assign bit_rate_divisor = baud_q;
  assign slave_match_compare = addr_q;
  assign halt_behaviour_ctl = dbg_q;
  assign irq_enable = inten_q;
  assign irq_flags = flags_q;
  assign shift_order_select = pri_q[spm_pkg::PRI_ORDER];
  assign core_enable = core_enable_q;
  assign rx_enable = rx_enable_q;
  assign tx_data = data_q[8:0];
  assign tx_data_write = data_we;
  assign rx_data_read = rd & hit(paddr, spm_pkg::OFS_DATA);

endmodule

// ===== verilog/spm_pkg.sv
// Purpose: shared offsets, field layouts, reset values and timing counts
//          for the serial peripheral register bank
// Assumes: byte addresses on a 32-bit peripheral bus with byte strobes
// Notes:   a register at a halfword offset sits in the matching lanes
package spm_pkg;

  // byte offsets of the register map
  localparam logic [5:0] OFS_PRI_CTL = 6'h00;
  localparam logic [5:0] OFS_SEC_CTL = 6'h04;
  localparam logic [5:0] OFS_BAUD = 6'h0C;
  localparam logic [5:0] OFS_IRQ_EN_CLR = 6'h14;
  localparam logic [5:0] OFS_IRQ_EN_SET = 6'h16;
  localparam logic [5:0] OFS_IRQ_FLAGS = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1A;
  localparam logic [5:0] OFS_SYNC_PEND = 6'h1C;
  localparam logic [5:0] OFS_ADDR = 6'h24;
  localparam logic [5:0] OFS_DATA = 6'h28;
  localparam logic [5:0] OFS_HALT_CTL = 6'h30;

  // primary control layout
  localparam int PRI_SOFT_RST = 0;
  localparam int PRI_ENABLE = 1;
  localparam int PRI_ORDER = 30;
  localparam logic [31:0] PRI_RST = 32'h0000_0000;
  localparam logic [31:0] PRI_WMASK = 32'h7F33_019E;
  localparam logic [31:0] PRI_EP_FREE = 32'h0000_0002;

  // secondary control layout
  localparam int SEC_RX_EN = 17;
  localparam logic [31:0] SEC_RST = 32'h0000_0000;
  localparam logic [31:0] SEC_WMASK = 32'h0002_A247;
  localparam logic [31:0] SEC_EP_FREE = 32'h0002_0000;

  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] BAUD_WMASK = 8'hFF;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_WMASK = 32'h00FF_00FF;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DATA_WMASK = 16'h01FF;
  localparam logic [7:0] DBG_RST = 8'h00;
  localparam logic [7:0] DBG_WMASK = 8'h01;

  // interrupt enable, flag and status layout
  localparam logic [7:0] IRQ_MASK = 8'h8F;
  localparam logic [7:0] INTEN_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] STATUS_W1C = 16'h0004;

  // byte lanes used inside shared words
  localparam int LANE_PRI_LOW = 0;
  localparam int LANE_SEC_RX = 2;
  localparam int LANE_EN_CLR = 0;
  localparam int LANE_EN_SET = 2;
  localparam int LANE_FLAGS = 0;

  // core clock cycles a write-synchronised operation stays busy
  localparam int SYNC_CYCLES = 4;

endpackage

// ===== verilog/spm_sync_busy.sv
// Purpose: busy tracker for one write-synchronised operation
// Assumes: start comes from the bus decode in the same clock domain
// Notes:   busy rises the edge after start, done pulses on the last cycle
module spm_sync_busy #(
  parameter int CYCLES = spm_pkg::SYNC_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [7:0] cnt_q;

  generate
    if (CYCLES < 1 || CYCLES > 255) begin : g_bad
      $error("spm_sync_busy: CYCLES must lie in 1..255");
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
    end else if (start) begin
      cnt_q <= 8'(CYCLES);
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign busy = (cnt_q != 8'h00);
  assign done = (cnt_q == 8'h01);

endmodule

// ===== verilog/spm_lane_reg.sv
// Purpose: register with per-byte write strobes and a per-bit write mask
// Assumes: W is a whole number of bytes
// Notes:   clr returns the register to its reset value at once
module spm_lane_reg #(
  parameter int W = 32,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clr,
  input wire logic we,
  input wire logic [W/8-1:0] be,
  input wire logic [W-1:0] wd,
  input wire logic [W-1:0] wm,
  output logic [W-1:0] value_q
);

  generate
    if (W < 8 || (W % 8) != 0) begin : g_bad
      $error("spm_lane_reg: W must be a whole number of bytes");
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      value_q <= RST;
    end else if (clr) begin
      value_q <= RST;
    end else if (we) begin
      for (int i = 0; i < W / 8; i++) begin
        if (be[i]) begin
          value_q[i*8 +: 8] <= (value_q[i*8 +: 8] & ~wm[i*8 +: 8]) |
                               (wd[i*8 +: 8] & wm[i*8 +: 8]);
        end
      end
    end
  end

endmodule

// ===== bench/spm_regbank_monitor.sv
// Purpose: concurrent checks on the register bank ports
// Assumes: one clock domain, pready tied high by the design
// Notes:   bound into every register bank instance
module spm_regbank_monitor #(
  parameter int SYNC_CYCLES = spm_pkg::SYNC_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic access_protection_lock,
  input wire logic [31:0] primary_control,
  input wire logic [31:0] secondary_control,
  input wire logic [7:0] bit_rate_divisor,
  input wire logic [31:0] slave_match_compare,
  input wire logic shift_order_select,
  input wire logic core_enable
);
  localparam int LAG = SYNC_CYCLES + 1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  wire logic wr_acc = psel && penable && pwrite;
  wire logic free_ok = !access_protection_lock && !primary_control[1] &&
    !primary_control[0];
  wire logic baud_wr = wr_acc && paddr == spm_pkg::OFS_BAUD;

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_reset_zero: assert property ($rose(reset_n) |->
    primary_control == spm_pkg::PRI_RST) else $error("reset value");
  a_bit31_zero: assert property (!primary_control[31])
    else $error("bit 31 set");
  a_order_write: assert property (wr_acc && paddr == 6'h00 &&
    pstrb == 4'h8 && free_ok |=> shift_order_select == $past(pwdata[30])
    && shift_order_select == primary_control[30])
    else $error("shift order wrong");
  a_lock_hold: assert property (baud_wr && access_protection_lock
    |=> $stable(bit_rate_divisor)) else $error("locked write taken");
  a_enabled_hold: assert property (baud_wr && primary_control[1]
    |=> $stable(bit_rate_divisor)) else $error("enabled write taken");
  a_lane_keep: assert property (wr_acc && paddr == spm_pkg::OFS_ADDR &&
    pstrb == 4'h4 && free_ok |=> slave_match_compare == {8'h00,
    $past(pwdata[23:16]), 8'h00, $past(slave_match_compare[7:0])})
    else $error("lane write wrong");
  a_enable_lag: assert property ($rose(primary_control[1]) |->
    ##[1:LAG] core_enable) else $error("enable never synced");
  a_err_phase: assert property (pslverr |-> wr_acc)
    else $error("error outside write");
  a_soft_reset_bit_clear: assert property ($rose(primary_control[0]) |->
    bit_rate_divisor == 8'h00 && slave_match_compare == 32'h0000_0000 &&
    secondary_control == 32'h0000_0000 ##[1:LAG]
    (!primary_control[0] && !core_enable)) else $error("soft reset");

  c_enable: cover property ($rose(core_enable));
  c_error: cover property (pslverr);
  c_soft_reset_bit: cover property ($rose(primary_control[0]));
endmodule

bind spm_regbank spm_regbank_monitor #(.SYNC_CYCLES(SYNC_CYCLES)) u_monitor (
  .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .pslverr, .access_protection_lock, .primary_control,
  .secondary_control, .bit_rate_divisor, .slave_match_compare,
  .shift_order_select, .core_enable);

// ===== bench/testbench.sv
// Purpose: self-checking bench for the register bank
// Assumes: inputs change at the falling edge, one idle cycle per access
// Notes:   every access queues its expected read data or error bit
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SYNC = 6;
  localparam logic [5:0] ZOFS [6] =
    '{6'h00, 6'h04, 6'h0C, 6'h1C, 6'h24, 6'h08};
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic access_protection_lock, shift_order_select, core_enable, rx_enable;
  logic tx_data_write, rx_data_read;
  logic [5:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, primary_control, secondary_control;
  logic [31:0] slave_match_compare, nt, seed, r;
  logic [7:0] event_set, bit_rate_divisor, halt_behaviour_ctl;
  logic [7:0] irq_enable, irq_flags;
  logic [15:0] status_set;
  logic [8:0] rx_data, tx_data;
  logic [31:0] exp_q[$];
  int fail_count, checks_done;
  logic data_hit;

  spm_regbank #(.SYNC_CYCLES(SYNC)) i_dut (.core_clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .access_protection_lock, .event_set, .status_set, .rx_data,
    .primary_control, .secondary_control, .bit_rate_divisor,
    .slave_match_compare, .halt_behaviour_ctl, .irq_enable, .irq_flags,
    .shift_order_select, .core_enable, .rx_enable, .tx_data, .tx_data_write,
    .rx_data_read);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] e);
    @(negedge core_clk);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = s;
    exp_q.push_back(e);
    @(negedge core_clk);
    penable = 1'b1;
    @(negedge core_clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic err);
    acc(1'b1, a, d, s, {31'h0, err});
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'h0, e);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic settle();
    repeat (SYNC + 2) @(negedge core_clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // takes the oldest note whenever an access phase completes
  always @(posedge core_clk) begin
    if (reset_n && psel && penable) begin
      nt = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
      data_hit = paddr[5:2] == 4'hA;
      if (pwrite) `CHK("pslverr", nt, {31'h0, pslverr})
      else `CHK("prdata", nt, prdata)
      `CHK("rx_data_read", !pwrite && data_hit, rx_data_read)
      `CHK("tx_data_write", pwrite && data_hit && !nt[0], tx_data_write)
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    #(4 * 5000);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, access_protection_lock, reset_n} = 5'h00;
    paddr = 6'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    event_set = 8'h00;
    status_set = 16'h0000;
    rx_data = 9'h000;
    seed = 32'h0000_E279;
    fail_count = 0;
    checks_done = 0;
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    r = xs();
    rx_data = r[8:0];
    foreach (ZOFS[i]) rd(ZOFS[i], 32'h0);
    done("reset");
    wr(6'h00, 32'h4000_0000, 4'h8, 1'b0);
    rd(6'h00, 32'h4000_0000);
    rd(6'h1C, 32'h0);
    `CHK("shift_order_select", 1'b1, shift_order_select)
    done("order");
    wr(6'h00, 32'h2, 4'h1, 1'b0);
    wr(6'h00, 32'h0, 4'h1, 1'b1);
    rd(6'h1C, 32'h2);
    settle();
    rd(6'h1C, 32'h0);
    `CHK("core_enable", 1'b1, core_enable)
    wr(6'h0C, 32'h55, 4'h1, 1'b0);
    rd(6'h0C, 32'h0);
    wr(6'h00, 32'h0, 4'h1, 1'b0);
    settle();
    `CHK("core_enable", 1'b0, core_enable)
    done("sync");
    access_protection_lock = 1'b1;
    wr(6'h0C, 32'hAA, 4'h1, 1'b0);
    rd(6'h0C, 32'h0);
    wr(6'h28, 32'h1AB, 4'h3, 1'b0);
    `CHK("tx_data", 9'h1AB, tx_data)
    access_protection_lock = 1'b0;
    done("protect");
    r = xs();
    wr(6'h0C, r, 4'h1, 1'b0);
    rd(6'h0C, {24'h0, r[7:0]});
    wr(6'h24, 32'hFFFF_FFFF, 4'h4, 1'b0);
    rd(6'h24, 32'h00FF_0000);
    wr(6'h24, r, 4'h3, 1'b0);
    rd(6'h24, {16'h00FF, 8'h00, r[7:0]});
    wr(6'h08, 32'hFFFF_FFFF, 4'hF, 1'b0);
    rd(6'h08, 32'h0);
    wr(6'h30, 32'h1, 4'h1, 1'b0);
    done("lanes");
    wr(6'h00, 32'h1, 4'h1, 1'b0);
    wr(6'h0C, 32'h12, 4'h1, 1'b1);
    rd(6'h00, 32'h1);
    settle();
    rd(6'h00, 32'h0);
    rd(6'h0C, 32'h0);
    rd(6'h24, 32'h0);
    rd(6'h30, 32'h1);
    `CHK("shift_order_select", 1'b0, shift_order_select)
    done("soft reset");
    r = xs();
    rx_data = r[8:0];
    rd(6'h28, {23'h0, r[8:0]});
    wr(6'h16, 32'h00FF_0000, 4'h4, 1'b0);
    `CHK("irq_enable", 8'h8F, irq_enable)
    wr(6'h14, 32'h0001_0003, 4'h5, 1'b0);
    rd(6'h14, 32'h008D_008D);
    `CHK("irq_enable", 8'h8D, irq_enable)
    event_set = 8'hFF;
    wr(6'h18, 32'h0000_0081, 4'h1, 1'b0);
    event_set = 8'h00;
    `CHK("irq_flags", 8'h8F, irq_flags)
    wr(6'h18, 32'h0000_0081, 4'h1, 1'b0);
    `CHK("irq_flags", 8'h0E, irq_flags)
    status_set = 16'hFFFF;
    @(negedge core_clk);
    status_set = 16'h0000;
    rd(6'h18, 32'h0004_000E);
    wr(6'h1A, 32'h0004_0000, 4'h4, 1'b0);
    rd(6'h18, 32'h0000_000E);
    done("flags");
    wr(6'h04, 32'h0002_0000, 4'h4, 1'b0);
    wr(6'h04, 32'h0002_0000, 4'h4, 1'b1);
    settle();
    `CHK("rx_enable", 1'b1, rx_enable)
    `CHK("secondary_control", 32'h0002_0000, secondary_control)
    `CHK("halt_behaviour_ctl", 8'h01, halt_behaviour_ctl)
    done("receiver");
    `CHK("leftover notes", 32'h0, 32'(exp_q.size()))
    tally_and_finish();
  end
endmodule
